// >>> config_lock_regs.vh
`ifndef CONFIG_LOCK_REGS_VH
`define CONFIG_LOCK_REGS_VH

// Register indices on the plain register port.
`define IDX_PIN_SEL_EXT1 8'h2a
`define IDX_BLOCK_LOCK 8'h2b
`define IDX_PIN_SEL_EXT2 8'h2c

// Logical device number that opens the pin selection registers to writes.
`define LDN_GLOBAL_CFG 8'h07

// Reset values.
`define RST_PIN_SEL_EXT1 8'h00
`define RST_BLOCK_LOCK 8'h00
`define RST_PIN_SEL_EXT2 8'h1f

// First pin selection register fields.
`define EXT1_THERMAL_BIT 6
`define EXT1_PIN_MSB 5
`define EXT1_WMASK 8'h7f

// Lock register fields.
`define LOCK_SW_EN_BIT 7
`define LOCK_GPIO_BIT 6
`define LOCK_KBD_MOUSE_BIT 5
`define LOCK_FAN_BIT 4
`define LOCK_PAR_BIT 3
`define LOCK_SER2_BIT 2
`define LOCK_SER1_BIT 1
`define LOCK_FDC_BIT 0

// Second pin selection register fields.
`define EXT2_FAN5_BIT 4
`define EXT2_FAN4_BIT 3
`define EXT2_RST5_BIT 2
`define EXT2_WMASK 8'h1c
`define EXT2_FORCED_ONES 8'h03

// Deferral bit of the clock-run pin in the GPIO set 5 selection.
`define SET5_PIN48_BIT 0

// Pin function codes reported per pin.
`define FUNC_DEDICATED 2'b00
`define FUNC_ALTERNATE 2'b01
`define FUNC_GPIO 2'b10

`endif

// >>> sync_two_stage.v
`default_nettype none

module sync_two_stage #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset.
  input wire clk_i,
  input wire rstn_i,
  // Asynchronous level in, synchronised level out.
  input wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;

  // The first stage feeds only the second, so no logic sees a metastable value.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= RST_VAL;
      stable <= RST_VAL;
    end else begin
      meta <= d_i;
      stable <= meta;
    end
  end

  assign q_o = stable;

endmodule

`default_nettype wire

// >>> pin_route_cell.v
`include "config_lock_regs.vh"
`default_nettype none

module pin_route_cell #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input wire clk_i,
  input wire rstn_i,
  // Selection bits per pin.
  input wire [WIDTH-1:0] ext_sel_i,
  input wire [WIDTH-1:0] gpio_sel_i,
  // Candidate drivers per pin.
  input wire [WIDTH-1:0] ded_d_i,
  input wire [WIDTH-1:0] ded_oe_i,
  input wire [WIDTH-1:0] alt_d_i,
  input wire [WIDTH-1:0] alt_oe_i,
  input wire [WIDTH-1:0] gpio_d_i,
  input wire [WIDTH-1:0] gpio_oe_i,
  // Registered pin drive and function code.
  output reg [WIDTH-1:0] pin_o,
  output reg [WIDTH-1:0] pin_oe_o,
  output reg [2*WIDTH-1:0] func_o
);

  integer i;

  // Clear selection keeps the dedicated function; a set bit defers to the second selector.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_o <= {WIDTH{1'b0}};
      pin_oe_o <= {WIDTH{1'b0}};
      func_o <= {(2*WIDTH){1'b0}};
    end else begin
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (!ext_sel_i[i]) begin
          pin_o[i] <= ded_d_i[i];
          pin_oe_o[i] <= ded_oe_i[i];
          func_o[2*i +: 2] <= `FUNC_DEDICATED;
        end else if (!gpio_sel_i[i]) begin
          pin_o[i] <= alt_d_i[i];
          pin_oe_o[i] <= alt_oe_i[i];
          func_o[2*i +: 2] <= `FUNC_ALTERNATE;
        end else begin
          pin_o[i] <= gpio_d_i[i];
          pin_oe_o[i] <= gpio_oe_i[i];
          func_o[2*i +: 2] <= `FUNC_GPIO;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> config_pin_mux_and_lock.v
`include "config_lock_regs.vh"
`default_nettype none

// Operation
// RL1: Pin selects readable anywhere, writable only LOGICAL_DEVICE_NUMBER 07h.
// RL2: Bit 6 picks motor-B select or thermal alarm.
// RL3: Bits 5-0 dedicated when clear, else GPIO set 1.
// RL4: Active lock freezes chosen blocks, clock select, itself.
// RL5: Software lock bit sticky until hardware reset.
// RL6: Lock bits 6-0 choose which blocks lock.
// RL7: Floppy write-protect bit stays writable under lock.
// RL8: Reset loads 00h, 00h and 1Fh.
// RL9: Bit 4 enables fan set 5, game port off.
// RL10: Bit 3 enables fan set 4, game port off.
// RL11: Bit 2 picks clock-run or bus reset 5.
// RL12: Software writes ones into the two low bits.
// RL13: Deferred pin 84 follows GPIO set 1 bit 0.
// RL14: GPIO set 5 bit 0 makes pin GPIO 50.
// RL15: Reserved bits read zero; two low bits read one.

module config_pin_mux_and_lock (
  // Clock and reset.
  input wire ref_clk_i,
  input wire rstn_i,

  // Register port.
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,

  // Context from the configuration front end.
  input wire [7:0] logical_device_number_i,
  input wire [7:0] gpio_set1_sel_i,
  input wire [7:0] gpio_set5_sel_i,
  input wire game_port_enabled_i,

  // External lock pin.
  input wire external_lock_n_i,

  // Lock status towards the logical blocks.
  output reg lock_active_o,
  output reg [7:0] ldn_locked_o,
  output reg fdc_wp_writable_o,
  output reg clock_select_locked_o,

  // Fan set enables.
  output reg fan_set4_enable_o,
  output reg fan_set5_enable_o,
  output reg game_port_conflict_o,

  // Dedicated functions of pins 30 to 34 and 84.
  input wire reset_connect_n_i,
  input wire bus_reset_out_1_n_i,
  input wire power_good_out_1_i,
  input wire bus_reset_out_2_n_i,
  input wire bus_reset_out_3_n_i,
  input wire bus_reset_out_4_n_i,

  // Deferred functions of pins 30 to 34 and 84, bit 0 is pin 84.
  input wire [5:0] alt_func_d_i,
  input wire [5:0] alt_func_oe_i,
  input wire [5:0] gpio_set1_d_i,
  input wire [5:0] gpio_set1_oe_i,

  // Drive of pins 30 to 34 and 84, bit 5 is pin 30.
  output wire [5:0] ext_pin_o,
  output wire [5:0] ext_pin_oe_o,
  output wire [11:0] ext_pin_func_o,

  // Pin 53 sources.
  input wire motor_b_select_n_i,
  input wire thermal_alarm_n_i,

  // Pin 53 drive.
  output wire pin53_o,
  output wire pin53_oe_o,
  output wire [1:0] pin53_func_o,

  // Pin 48 sources.
  input wire clkrun_drive_low_i,
  input wire bus_reset_out_5_n_i,
  input wire gpio_line_50_d_i,
  input wire gpio_line_50_oe_i,

  // Pin 48 drive.
  output wire pin48_o,
  output wire pin48_oe_o,
  output wire [1:0] pin48_func_o
);

  // Synchronised reset and lock pin.
  wire rst_n;
  wire ext_lock_n;

  // Register state.
  reg [7:0] pin_sel_ext1;
  reg [7:0] block_lock;
  reg [7:0] pin_sel_ext2;

  // Next values.
  reg [7:0] next_pin_sel_ext1;
  reg [7:0] next_block_lock;
  reg [7:0] next_pin_sel_ext2;
  reg [7:0] next_rdata;

  // Decoded accesses.
  wire ldn_global;
  wire lock_now;
  reg wr_ext1;
  reg wr_lock;
  reg wr_ext2;

  // Pin 48 dedicated candidate.
  wire pin48_ded_d;
  wire pin48_ded_oe;

  // Reset enters asynchronously and is released through two flip-flops.
  sync_two_stage #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_reset_sync (
    .clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .d_i(1'b1),
    .q_o(rst_n)
  );

  // The lock pin is asynchronous, so it is synchronised; it resets to unlocked.
  sync_two_stage #(
    .WIDTH(1),
    .RST_VAL(1'b1)
  ) u_lock_pin_sync (
    .clk_i(ref_clk_i),
    .rstn_i(rst_n),
    .d_i(external_lock_n_i),
    .q_o(ext_lock_n)
  );

  // Write gating for the pin selection registers.
  assign ldn_global = (logical_device_number_i == `LDN_GLOBAL_CFG); // [RL1]

  // Lock is live on the software bit or a low pin.
  assign lock_now = block_lock[`LOCK_SW_EN_BIT] | ~ext_lock_n; // [RL4] [RL5]

  // Address decode of writes; reads ignore the device number.
  always @* begin
    wr_ext1 = 1'b0;
    wr_lock = 1'b0;
    wr_ext2 = 1'b0;
    if (wr_i && addr_i == `IDX_PIN_SEL_EXT1) begin
      wr_ext1 = ldn_global; // [RL1]
    end else if (wr_i && addr_i == `IDX_BLOCK_LOCK) begin
      wr_lock = ~lock_now; // [RL4]
    end else if (wr_i && addr_i == `IDX_PIN_SEL_EXT2) begin
      wr_ext2 = ldn_global; // [RL1]
    end
  end

  // Next register values; reserved bits never take a one.
  always @* begin
    next_pin_sel_ext1 = pin_sel_ext1;
    next_block_lock = block_lock;
    next_pin_sel_ext2 = pin_sel_ext2;
    if (wr_ext1) begin
      next_pin_sel_ext1 = wdata_i & `EXT1_WMASK; // [RL15]
    end
    if (wr_lock) begin
      // The enable bit only ever sets; nothing but reset clears it.
      next_block_lock = wdata_i | (block_lock & 8'h80); // [RL5] [RL6]
    end
    if (wr_ext2) begin
      // The two low bits are forced, so a careless write cannot clear them.
      next_pin_sel_ext2 = (wdata_i & `EXT2_WMASK) | `EXT2_FORCED_ONES; // [RL12] [RL15]
    end
  end

  // Register storage.
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_sel_ext1 <= `RST_PIN_SEL_EXT1; // [RL8]
      block_lock <= `RST_BLOCK_LOCK; // [RL8]
      pin_sel_ext2 <= `RST_PIN_SEL_EXT2; // [RL8]
    end else begin
      pin_sel_ext1 <= next_pin_sel_ext1;
      block_lock <= next_block_lock;
      pin_sel_ext2 <= next_pin_sel_ext2;
    end
  end

  // Read multiplexer; unmapped indices answer zero.
  always @* begin
    next_rdata = 8'h00;
    if (addr_i == `IDX_PIN_SEL_EXT1) begin
      next_rdata = pin_sel_ext1; // [RL1]
    end else if (addr_i == `IDX_BLOCK_LOCK) begin
      next_rdata = block_lock;
    end else if (addr_i == `IDX_PIN_SEL_EXT2) begin
      next_rdata = pin_sel_ext2; // [RL1] [RL15]
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Lock status per logical device; the keyboard bit covers both devices 5 and 6.
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_active_o <= 1'b0;
      ldn_locked_o <= 8'h00;
      fdc_wp_writable_o <= 1'b1;
      clock_select_locked_o <= 1'b0;
    end else begin
      lock_active_o <= lock_now; // [RL4]
      clock_select_locked_o <= lock_now; // [RL4]
      ldn_locked_o[0] <= lock_now & block_lock[`LOCK_FDC_BIT]; // [RL6]
      ldn_locked_o[1] <= lock_now & block_lock[`LOCK_SER1_BIT]; // [RL6]
      ldn_locked_o[2] <= lock_now & block_lock[`LOCK_SER2_BIT]; // [RL6]
      ldn_locked_o[3] <= lock_now & block_lock[`LOCK_PAR_BIT]; // [RL6]
      ldn_locked_o[4] <= lock_now & block_lock[`LOCK_FAN_BIT]; // [RL6]
      ldn_locked_o[5] <= lock_now & block_lock[`LOCK_KBD_MOUSE_BIT]; // [RL6]
      ldn_locked_o[6] <= lock_now & block_lock[`LOCK_KBD_MOUSE_BIT]; // [RL6]
      ldn_locked_o[7] <= lock_now & block_lock[`LOCK_GPIO_BIT]; // [RL6]
      // The write-protect bit is exempt, so this stays high whatever the lock does.
      fdc_wp_writable_o <= 1'b1; // [RL7]
    end
  end

  // Fan sets and a warning when the game port still claims the shared pins.
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fan_set4_enable_o <= 1'b0;
      fan_set5_enable_o <= 1'b0;
      game_port_conflict_o <= 1'b0;
    end else begin
      fan_set5_enable_o <= pin_sel_ext2[`EXT2_FAN5_BIT]; // [RL9]
      fan_set4_enable_o <= pin_sel_ext2[`EXT2_FAN4_BIT]; // [RL10]
      game_port_conflict_o <= game_port_enabled_i &
        (pin_sel_ext2[`EXT2_FAN5_BIT] | pin_sel_ext2[`EXT2_FAN4_BIT]); // [RL9] [RL10]
    end
  end

  // Pins 30 to 34 and 84: a clear bit keeps the dedicated output.
  pin_route_cell #(
    .WIDTH(6)
  ) u_ext_pins (
    .clk_i(ref_clk_i),
    .rstn_i(rst_n),
    .ext_sel_i(pin_sel_ext1[`EXT1_PIN_MSB:0]), // [RL3]
    .gpio_sel_i(gpio_set1_sel_i[5:0]), // [RL3] [RL13]
    .ded_d_i({reset_connect_n_i, bus_reset_out_1_n_i, power_good_out_1_i,
      bus_reset_out_2_n_i, bus_reset_out_3_n_i, bus_reset_out_4_n_i}),
    .ded_oe_i(6'h3f),
    .alt_d_i(alt_func_d_i),
    .alt_oe_i(alt_func_oe_i),
    .gpio_d_i(gpio_set1_d_i),
    .gpio_oe_i(gpio_set1_oe_i),
    .pin_o(ext_pin_o),
    .pin_oe_o(ext_pin_oe_o),
    .func_o(ext_pin_func_o)
  );

  // Pin 53 has no GPIO choice, so the second selector is held clear.
  pin_route_cell #(
    .WIDTH(1)
  ) u_pin53 (
    .clk_i(ref_clk_i),
    .rstn_i(rst_n),
    .ext_sel_i(pin_sel_ext1[`EXT1_THERMAL_BIT]), // [RL2]
    .gpio_sel_i(1'b0),
    .ded_d_i(motor_b_select_n_i),
    .ded_oe_i(1'b1),
    .alt_d_i(thermal_alarm_n_i),
    .alt_oe_i(1'b1),
    .gpio_d_i(1'b0),
    .gpio_oe_i(1'b0),
    .pin_o(pin53_o),
    .pin_oe_o(pin53_oe_o),
    .func_o(pin53_func_o)
  );

  // Clock-run is open drain: it drives low only while asked to.
  assign pin48_ded_d = pin_sel_ext2[`EXT2_RST5_BIT] ? bus_reset_out_5_n_i : 1'b0; // [RL11]
  assign pin48_ded_oe = pin_sel_ext2[`EXT2_RST5_BIT] | clkrun_drive_low_i; // [RL11]

  // Pin 48: GPIO 50 overrides both dedicated choices.
  pin_route_cell #(
    .WIDTH(1)
  ) u_pin48 (
    .clk_i(ref_clk_i),
    .rstn_i(rst_n),
    .ext_sel_i(gpio_set5_sel_i[`SET5_PIN48_BIT]), // [RL14]
    .gpio_sel_i(1'b1),
    .ded_d_i(pin48_ded_d),
    .ded_oe_i(pin48_ded_oe),
    .alt_d_i(1'b0),
    .alt_oe_i(1'b0),
    .gpio_d_i(gpio_line_50_d_i),
    .gpio_oe_i(gpio_line_50_oe_i),
    .pin_o(pin48_o),
    .pin_oe_o(pin48_oe_o),
    .func_o(pin48_func_o)
  );

endmodule

`default_nettype wire

// >>> config_pin_mux_and_lock_assertions.sv
`default_nettype none

module config_pin_mux_and_lock_chk (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Context and pin sources.
  input wire logic external_lock_n_i,
  input wire logic game_port_enabled_i,
  input wire logic motor_b_select_n_i,
  input wire logic thermal_alarm_n_i,
  input wire logic [7:0] gpio_set5_sel_i,
  input wire logic gpio_line_50_d_i,
  input wire logic gpio_line_50_oe_i,
  // Lock and fan status.
  input wire logic lock_active_o,
  input wire logic [7:0] ldn_locked_o,
  input wire logic fdc_wp_writable_o,
  input wire logic clock_select_locked_o,
  input wire logic fan_set4_enable_o,
  input wire logic fan_set5_enable_o,
  input wire logic game_port_conflict_o,
  // Pin drive.
  input wire logic pin53_o,
  input wire logic pin53_oe_o,
  input wire logic [1:0] pin53_func_o,
  input wire logic pin48_o,
  input wire logic pin48_oe_o,
  input wire logic [1:0] pin48_func_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  logic rd_q;
  logic sticky;

  // Tracks lock register reads, since the sticky bit is only visible through the port.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_q <= 1'b0;
      sticky <= 1'b0;
    end else begin
      rd_q <= rd_i && addr_i == 8'h2b;
      sticky <= sticky | (rd_q & rdata_o[7]);
    end
  end

  property p_ext2_rd;
    rd_i && addr_i == 8'h2c |=> rdata_o[7:5] == 3'h0 && rdata_o[1:0] == 2'h3;
  endproperty
  a_ext2_rd: assert property (p_ext2_rd) else $error("ext2 reserved bits wrong");

  property p_clk_lock;
    clock_select_locked_o == lock_active_o;
  endproperty
  a_clk_lock: assert property (p_clk_lock) else $error("clock select lock differs");

  property p_pin_lock;
    !external_lock_n_i [*6] |-> lock_active_o;
  endproperty
  a_pin_lock: assert property (p_pin_lock) else $error("lock pin ignored");

  property p_sw_lock;
    rd_q && rdata_o[7] |-> lock_active_o;
  endproperty
  a_sw_lock: assert property (p_sw_lock) else $error("software lock ignored");

  property p_sticky;
    rd_q && sticky |-> rdata_o[7];
  endproperty
  a_sticky: assert property (p_sticky) else $error("software lock cleared");

  property p_ldn_map;
    ldn_locked_o[6] == ldn_locked_o[5] && (lock_active_o || ldn_locked_o == 8'h00);
  endproperty
  a_ldn_map: assert property (p_ldn_map) else $error("device lock map wrong");

  property p_wp;
    fdc_wp_writable_o;
  endproperty
  a_wp: assert property (p_wp) else $error("write protect locked");

  property p_fan_gp;
    game_port_conflict_o == ($past(game_port_enabled_i) && (fan_set4_enable_o || fan_set5_enable_o));
  endproperty
  a_fan_gp: assert property (p_fan_gp) else $error("game port conflict wrong");

  property p_pin53;
    pin53_oe_o |-> pin53_o == (pin53_func_o[0] ? $past(thermal_alarm_n_i) : $past(motor_b_select_n_i));
  endproperty
  a_pin53: assert property (p_pin53) else $error("pin53 source wrong");

  property p_gpio50;
    pin48_func_o == 2'h2 |-> $past(gpio_set5_sel_i[0]) && pin48_o == $past(gpio_line_50_d_i)
      && pin48_oe_o == $past(gpio_line_50_oe_i);
  endproperty
  a_gpio50: assert property (p_gpio50) else $error("pin48 gpio wrong");
endmodule

bind config_pin_mux_and_lock config_pin_mux_and_lock_chk i_config_pin_mux_and_lock_chk (.*);

`default_nettype wire

// >>> tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = '0, rstn = '0, wr = '0, rd = '0, gp = '0, xl = '1, mb = '1, th = '1;
  logic cr = '0, b5 = '1, g5d = '0, g5e = '0, la, wp, cs, f4, f5, gc, p53, p53e, p48, p48e;
  logic [7:0] addr = '0, wd = '0, logical_device_number = '0, s1 = '0, s5 = '0, rdata, lk;
  logic [5:0] dd = 6'h16, ad = 6'h2a, ao = 6'h3c, gd = 6'h15, go = 6'h03, ep, epe;
  logic [11:0] epf;
  logic [1:0] p53f, p48f;
  int failures = 0, samples_checked = 0;
  // Rows: device number, index, write data, expected read back.
  logic [31:0] rows [7] = '{32'h072a_ff7f, 32'h002a_007f, 32'h072c_0303, 32'h052c_ff03,
    32'h072c_e707, 32'h072a_4141, 32'h0730_ff00};

  // 25 MHz clock.
  always #20 clk = ~clk;

  config_pin_mux_and_lock i_config_pin_mux_and_lock (
    .ref_clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .logical_device_number_i(logical_device_number), .gpio_set1_sel_i(s1),
    .gpio_set5_sel_i(s5), .game_port_enabled_i(gp), .external_lock_n_i(xl),
    .lock_active_o(la), .ldn_locked_o(lk), .fdc_wp_writable_o(wp),
    .clock_select_locked_o(cs), .fan_set4_enable_o(f4), .fan_set5_enable_o(f5),
    .game_port_conflict_o(gc), .reset_connect_n_i(dd[5]), .bus_reset_out_1_n_i(dd[4]),
    .power_good_out_1_i(dd[3]), .bus_reset_out_2_n_i(dd[2]), .bus_reset_out_3_n_i(dd[1]),
    .bus_reset_out_4_n_i(dd[0]), .alt_func_d_i(ad), .alt_func_oe_i(ao),
    .gpio_set1_d_i(gd), .gpio_set1_oe_i(go), .ext_pin_o(ep), .ext_pin_oe_o(epe),
    .ext_pin_func_o(epf), .motor_b_select_n_i(mb), .thermal_alarm_n_i(th),
    .pin53_o(p53), .pin53_oe_o(p53e), .pin53_func_o(p53f), .clkrun_drive_low_i(cr),
    .bus_reset_out_5_n_i(b5), .gpio_line_50_d_i(g5d), .gpio_line_50_oe_i(g5e),
    .pin48_o(p48), .pin48_oe_o(p48e), .pin48_func_o(p48f));

  // Case equality, so an unknown never passes.
  task automatic check(string n, logic [11:0] e, logic [11:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wrr(logic [7:0] l, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    logical_device_number <= l;
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check("rdata", {4'h0, e}, {4'h0, rdata});
  endtask

  task automatic st(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Ten cycles of reset, then wait past the internal release.
  task automatic rst;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // A hang counts as a mismatch.
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    stop_test();
  end

  initial begin
    rst();
    foreach (rows[i]) begin
      wrr(rows[i][31:24], rows[i][23:16], rows[i][15:8]);
      rdc(rows[i][23:16], rows[i][7:0]);
    end
    $display("test table done");
    rst();
    rdc(8'h2a, 8'h00);
    rdc(8'h2b, 8'h00);
    rdc(8'h2c, 8'h1f);
    check("ext_pin", {6'h00, 6'h16}, {6'h00, ep});
    check("pin53", 12'h00c, {8'h00, p53, p53e, p53f});
    $display("test reset done");
    // Pins 30 to 34 alternate, pin 84 GPIO, pin 53 thermal.
    wrr(8'h07, 8'h2a, 8'h7f);
    s1 <= 8'h01;
    th <= 1'b0;
    st(3);
    check("ext_pin", {6'h00, 6'h2b}, {6'h00, ep});
    check("ext_oe", {6'h00, 6'h3d}, {6'h00, epe});
    check("ext_func", 12'h556, epf);
    check("pin53", 12'h005, {8'h00, p53, p53e, p53f});
    wrr(8'h07, 8'h2c, 8'h07);
    st(3);
    check("pin48", 12'h00c, {8'h00, p48, p48e, p48f});
    wrr(8'h07, 8'h2c, 8'h1b);
    cr <= 1'b1;
    gp <= 1'b1;
    st(3);
    check("pin48", 12'h004, {8'h00, p48, p48e, p48f});
    check("fan", 12'h007, {9'h000, f4, f5, gc});
    @(posedge clk);
    s5 <= 8'h01;
    g5d <= 1'b1;
    gp <= 1'b0;
    st(3);
    check("pin48", 12'h00a, {8'h00, p48, p48e, p48f});
    check("fan", 12'h006, {9'h000, f4, f5, gc});
    $display("test pins done");
    // Lock by pin, then by the sticky software bit.
    wrr(8'h00, 8'h2b, 8'h60);
    st(3);
    check("locked", 12'h000, {2'h0, cs, la, lk});
    @(posedge clk);
    xl <= 1'b0;
    st(5);
    check("locked", 12'h3e0, {2'h0, cs, la, lk});
    wrr(8'h07, 8'h2b, 8'h7f);
    rdc(8'h2b, 8'h60);
    @(posedge clk);
    xl <= 1'b1;
    st(5);
    check("locked", 12'h000, {3'h0, la, lk});
    wrr(8'h00, 8'h2b, 8'h85);
    rdc(8'h2b, 8'h85);
    check("locked", 12'h305, {2'h0, cs, la, lk});
    check("wp", 12'h001, {11'h000, wp});
    wrr(8'h00, 8'h2b, 8'h00);
    rdc(8'h2b, 8'h85);
    rst();
    rdc(8'h2b, 8'h00);
    $display("test lock done");
    stop_test();
  end
endmodule

`default_nettype wire
